// ==== rtl/pcicfg_cfg.svh ====
// Summary of operation
// - Interrupt routing level is a byte that holds whatever the host writes.
// - Interrupt signal select always reads 0x01, the INTA# line only.
// - Only bits 31 to 8 and bit 0 of the I/O window base are writable.
// - Bit 0 of the I/O window base is a writable valid flag.
// - Bus tenure limit sits in bits 7 to 3, in units of eight clocks.
// - Tenure counter is loaded and started whenever the device asserts FRAME#.
// - After expiry, release the bus once GNT# is seen deasserted.
// - Bus request interval is a read-only byte at 0x3F, default 0x05.
// - Auto-initialization loads the bus request interval from the EEPROM setup byte.
`ifndef PCICFG_CFG_SVH
`define PCICFG_CFG_SVH

// ==========================================================
// Config space dword offsets, plus the request interval byte offset
`define PCICFG_OFS_LAT_DW     8'h0C
`define PCICFG_OFS_IOBASE_DW  8'h10
`define PCICFG_OFS_INT_DW     8'h3C
`define PCICFG_OFS_REQ_IVL    8'h3F

// ==========================================================
// Field layout and reset values
`define PCICFG_INT_SEL_VAL    8'h01
`define PCICFG_REQ_IVL_RST    8'h05
`define PCICFG_INT_LINE_RST   8'h00
`define PCICFG_LAT_RST        5'h00
`define PCICFG_IO_LSB         8
`define PCICFG_LAT_LSB        3

// ==========================================================
// Timing
`define PCICFG_TENURE_UNIT    3
`define PCICFG_CLK_NS         10
`define PCICFG_REQ_UNIT_NS    250
`define PCICFG_REQ_UNIT_CYC   (`PCICFG_REQ_UNIT_NS / `PCICFG_CLK_NS)

`endif

// ==== rtl/pcicfg_pkg.sv ====
package pcicfg_pkg;
    typedef logic [7:0]  pcicfg_byte_t;
    typedef logic [31:0] pcicfg_word_t;
    typedef logic [3:0]  pcicfg_be_t;
endpackage

// ==== rtl/pcicfg_ten_if.sv ====
`timescale 1ns/10ps
interface pcicfg_ten_if;
    logic       load;
    logic [4:0] limit;
    logic       expired;
    modport regs (output load, output limit, input expired);
    modport tmr  (input load, input limit, output expired);
endinterface

// ==== rtl/pcicfg_tenure.sv ====
`timescale 1ns/10ps
`include "pcicfg_cfg.svh"
module pcicfg_tenure (
    // Clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    // Counter control
    pcicfg_ten_if.tmr   ten
);
    import pcicfg_pkg::*;

    logic [7:0] cnt_r;
    logic       armed_r;

    // ==========================================================
    // Tenure counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r   <= 8'h00;
            armed_r <= 1'b0;
        end else if (ten.load) begin
            cnt_r   <= {ten.limit, 3'b000};
            armed_r <= 1'b1;
        end else if (cnt_r != 8'h00) begin
            cnt_r   <= cnt_r - 8'h01;
        end
    end

    // Idle until the first frame so a stale zero never reads as expiry
    assign ten.expired = armed_r && (cnt_r == 8'h00);

    a_load_zero:   assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ten.load && ten.limit == 5'h00 |=> ten.expired) else $error("zero limit did not expire");
    a_load_holds:  assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ten.load && ten.limit != 5'h00 |=> !ten.expired [*8]) else $error("tenure expired early");
endmodule

// ==== rtl/pcicfg_regs.sv ====
`timescale 1ns/10ps
`include "pcicfg_cfg.svh"
module pcicfg_regs (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Configuration access
    input  wire logic                 i_cfg_wr,
    input  wire logic                 i_cfg_rd,
    input  wire logic [7:0]           i_cfg_addr,
    input  wire pcicfg_pkg::pcicfg_be_t   i_cfg_be,
    input  wire pcicfg_pkg::pcicfg_word_t i_cfg_wdata,
    output      pcicfg_pkg::pcicfg_word_t o_cfg_rdata,
    output      logic                 o_cfg_rvalid,
    // EEPROM auto-initialization
    input  wire logic                 i_ee_load,
    input  wire pcicfg_pkg::pcicfg_byte_t i_ee_setup_param,
    // Bus master tenure
    input  wire logic                 i_frame_start,
    input  wire logic                 i_master_busy,
    input  wire logic                 i_gnt_n,
    output      logic                 o_tenure_release,
    // I/O target decode
    input  wire logic                 i_io_cycle,
    input  wire pcicfg_pkg::pcicfg_word_t i_io_addr,
    output      logic                 o_io_hit,
    output      pcicfg_pkg::pcicfg_byte_t o_io_offset,
    // Interrupt routing
    output      pcicfg_pkg::pcicfg_byte_t o_interrupt_routing_level
);
    import pcicfg_pkg::*;

    pcicfg_ten_if ten ();

    logic [23:0]  io_base_r;
    logic         io_valid_r;
    logic [4:0]   lat_r;
    pcicfg_byte_t req_ivl_r;
    pcicfg_byte_t int_line_r;
    logic         gnt_n_meta_r;
    logic         gnt_n_sync_r;
    logic [7:0]   rd_addr_r;
    pcicfg_word_t wr_merged;

    // ==========================================================
    // Byte-lane merge, used only by the I/O window base dword
    function automatic pcicfg_word_t lane_merge(input pcicfg_word_t old_v, input pcicfg_word_t new_v,
                                                input pcicfg_be_t be);
        pcicfg_word_t res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic hit_dw(input logic [7:0] addr, input logic [7:0] ofs);
        return {addr[7:2], 2'b00} == {ofs[7:2], 2'b00};
    endfunction

    assign wr_merged = lane_merge({io_base_r, 7'h00, io_valid_r}, i_cfg_wdata, i_cfg_be);

    // ==========================================================
    // I/O window base; low bits 7 to 1 are not stored
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            io_base_r  <= 24'h00_0000;
            io_valid_r <= 1'b0;
        end else if (i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_IOBASE_DW)) begin
            io_base_r  <= wr_merged[31:`PCICFG_IO_LSB];
            io_valid_r <= wr_merged[0];
        end
    end

    // ==========================================================
    // Tenure limit and interrupt routing level
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_r <= `PCICFG_LAT_RST;
        end else if (i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_LAT_DW) && i_cfg_be[1]) begin
            lat_r <= i_cfg_wdata[15:8+`PCICFG_LAT_LSB];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_line_r <= `PCICFG_INT_LINE_RST;
        end else if (i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_INT_DW) && i_cfg_be[0]) begin
            int_line_r <= i_cfg_wdata[7:0];
        end
    end

    // ==========================================================
    // Bus request interval; read-only to config writes
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_ivl_r <= `PCICFG_REQ_IVL_RST;
        end else if (i_ee_load) begin
            req_ivl_r <= i_ee_setup_param;
        end
    end

    // ==========================================================
    // Read path, one cycle latency; reserved bits read zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_rdata  <= 32'h0000_0000;
            o_cfg_rvalid <= 1'b0;
            rd_addr_r    <= 8'h00;
        end else begin
            o_cfg_rvalid <= i_cfg_rd;
            rd_addr_r    <= i_cfg_addr;
            if (!i_cfg_rd) begin
                o_cfg_rdata <= 32'h0000_0000;
            end else if (hit_dw(i_cfg_addr, `PCICFG_OFS_IOBASE_DW)) begin
                o_cfg_rdata <= {io_base_r, 7'h00, io_valid_r};
            end else if (hit_dw(i_cfg_addr, `PCICFG_OFS_LAT_DW)) begin
                o_cfg_rdata <= {16'h0000, lat_r, 3'b000, 8'h00};
            end else if (hit_dw(i_cfg_addr, `PCICFG_OFS_INT_DW)) begin
                o_cfg_rdata <= {req_ivl_r, 8'h00, `PCICFG_INT_SEL_VAL, int_line_r};
            end else begin
                o_cfg_rdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Tenure control; GNT# is a pin, so it is synchronised first
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gnt_n_meta_r <= 1'b1;
            gnt_n_sync_r <= 1'b1;
        end else begin
            gnt_n_meta_r <= i_gnt_n;
            gnt_n_sync_r <= gnt_n_meta_r;
        end
    end

    assign ten.load  = i_frame_start;
    assign ten.limit = lat_r;

    pcicfg_tenure u_tenure (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .ten     (ten)
    );

    // Release only once grant is gone; a held grant lets the burst run on
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tenure_release <= 1'b0;
        end else begin
            o_tenure_release <= i_master_busy && !i_frame_start && ten.expired && gnt_n_sync_r;
        end
    end

    // ==========================================================
    // I/O decode and interrupt routing outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_io_hit                  <= 1'b0;
            o_io_offset               <= 8'h00;
            o_interrupt_routing_level <= `PCICFG_INT_LINE_RST;
        end else begin
            o_io_hit                  <= i_io_cycle && io_valid_r && (i_io_addr[31:8] == io_base_r);
            o_io_offset               <= i_io_addr[7:0];
            o_interrupt_routing_level <= int_line_r;
        end
    end

    // ==========================================================
    // Checks
    a_line_keeps:  assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_INT_DW) && i_cfg_be[0]
        |=> ##1 o_interrupt_routing_level == $past(i_cfg_wdata[7:0], 2)) else $error("routing level lost");
    a_select_const: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_cfg_rvalid && hit_dw(rd_addr_r, `PCICFG_OFS_INT_DW) |-> o_cfg_rdata[15:8] == 8'h01)
        else $error("signal select not 0x01");
    a_io_low_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_cfg_rvalid && hit_dw(rd_addr_r, `PCICFG_OFS_IOBASE_DW) |-> o_cfg_rdata[7:1] == 7'h00)
        else $error("io base low bits set");
    a_io_valid:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_IOBASE_DW) && i_cfg_be[0]
        |=> io_valid_r == $past(i_cfg_wdata[0])) else $error("valid flag not stored");
    a_lat_read:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_cfg_rvalid && hit_dw(rd_addr_r, `PCICFG_OFS_LAT_DW) |-> o_cfg_rdata[10:8] == 3'b000 &&
        o_cfg_rdata[15:11] == $past(lat_r)) else $error("tenure limit read wrong");
    a_release_gnt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_tenure_release |-> $past(gnt_n_sync_r) && $past(ten.expired)) else $error("released under grant");
    a_release_due: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_master_busy && !i_frame_start && ten.expired && gnt_n_sync_r |=> o_tenure_release)
        else $error("release missed");
    a_ivl_read:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_cfg_rvalid && hit_dw(rd_addr_r, `PCICFG_OFS_INT_DW) |-> o_cfg_rdata[31:24] == $past(req_ivl_r))
        else $error("request interval read wrong");
    a_ivl_load:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ee_load |=> req_ivl_r == $past(i_ee_setup_param)) else $error("eeprom value not loaded");
    a_io_claim:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_io_cycle && io_valid_r && i_io_addr[31:8] == io_base_r && !i_cfg_wr |=> o_io_hit)
        else $error("io cycle not claimed");

    // ==========================================================
    // Hold checks; state moves only on its own strobe
    a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cfg_rd |=> o_cfg_rvalid) else $error("read not answered");
    a_read_idle:   assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_cfg_rd |=> !o_cfg_rvalid && o_cfg_rdata == 32'h0000_0000) else $error("read data not idle");
    a_ivl_hold:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_ee_load |=> $stable(req_ivl_r)) else $error("request interval changed");
    a_line_hold:   assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_INT_DW) && i_cfg_be[0]) |=> $stable(int_line_r))
        else $error("routing level changed");
    a_base_hold:   assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_IOBASE_DW)) |=> $stable(io_base_r) && $stable(io_valid_r))
        else $error("io base changed");
    a_lat_hold:    assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_cfg_wr && hit_dw(i_cfg_addr, `PCICFG_OFS_LAT_DW) && i_cfg_be[1]) |=> $stable(lat_r))
        else $error("tenure limit changed");
    a_io_miss:     assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(i_io_cycle && io_valid_r && i_io_addr[31:8] == io_base_r) |=> !o_io_hit)
        else $error("io cycle claimed wrongly");
    a_io_offset:   assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_io_cycle |=> o_io_offset == $past(i_io_addr[7:0])) else $error("io offset wrong");
    a_frame_hold:  assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_frame_start |=> !o_tenure_release) else $error("released on a frame start");
endmodule

// ==== verif/pcicfg_arb_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Arbiter model: hands out or takes back GNT#
module pcicfg_arb_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Grant control
    input  wire logic i_grant,
    input  wire logic i_slow,
    // Grant pin
    output      logic o_gnt_n
);
    logic [2:0] grant_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            grant_r <= 3'h0;
        end else begin
            grant_r <= {grant_r[1:0], i_grant};
        end
    end

    // Slow mode lags three edges, so a master sees the change late
    assign o_gnt_n = i_slow ? ~grant_r[2] : ~grant_r[0];
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`include "pcicfg_cfg.svh"
module tb_top;
    import pcicfg_pkg::*;
    logic         i_clk = 1'b0, i_rst_n = 1'b0, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_ee_load = 1'b0;
    logic         i_frame_start = 1'b0, i_master_busy = 1'b0, i_io_cycle = 1'b0, gnt_n;
    logic         arb_grant = 1'b1, arb_slow = 1'b0, o_cfg_rvalid, o_tenure_release, o_io_hit;
    logic [7:0]   i_cfg_addr = 8'h00;
    pcicfg_be_t   i_cfg_be = 4'h0;
    pcicfg_word_t i_cfg_wdata = 32'h0000_0000, i_io_addr = 32'h0000_0000, o_cfg_rdata, d;
    pcicfg_byte_t i_ee_setup_param = 8'h00, o_io_offset, o_interrupt_routing_level, rl, ivl;
    pcicfg_word_t exp_q[$], msk_q[$];
    logic [4:0]   lim = 5'h02;
    int           seed, cycles = 0, fails = 0, n_compared = 0;

    pcicfg_regs uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
        .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
        .o_cfg_rvalid(o_cfg_rvalid), .i_ee_load(i_ee_load), .i_ee_setup_param(i_ee_setup_param),
        .i_frame_start(i_frame_start), .i_master_busy(i_master_busy), .i_gnt_n(gnt_n),
        .o_tenure_release(o_tenure_release), .i_io_cycle(i_io_cycle), .i_io_addr(i_io_addr),
        .o_io_hit(o_io_hit), .o_io_offset(o_io_offset), .o_interrupt_routing_level(o_interrupt_routing_level));
    pcicfg_arb_model arb (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_grant(arb_grant), .i_slow(arb_slow), .o_gnt_n(gnt_n));

    always #5 i_clk = ~i_clk;

    // ==========================================
    // Shared tasks
    task automatic check(input string name, input pcicfg_word_t seen, input pcicfg_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cfg_wr(input logic [7:0] a, input pcicfg_be_t be, input pcicfg_word_t w);
        @(posedge i_clk);
        i_cfg_wr <= 1'b1;
        i_cfg_addr <= a;
        i_cfg_be <= be;
        i_cfg_wdata <= w;
        @(posedge i_clk);
        i_cfg_wr <= 1'b0;
    endtask
    task automatic cfg_rd(input logic [7:0] a, input pcicfg_word_t exp, input pcicfg_word_t msk);
        @(posedge i_clk);
        i_cfg_rd <= 1'b1;
        i_cfg_addr <= a;
        exp_q.push_back(exp & msk);
        msk_q.push_back(msk);
        @(posedge i_clk);
        i_cfg_rd <= 1'b0;
    endtask
    task automatic io_try(input pcicfg_word_t a, input logic hit);
        @(posedge i_clk);
        i_io_cycle <= 1'b1;
        i_io_addr <= a;
        @(posedge i_clk);
        i_io_cycle <= 1'b0;
        #1 check("io hit", {31'h0, o_io_hit}, {31'h0, hit});
        if (hit) check("io offset", {24'h0, o_io_offset}, {24'h0, a[7:0]});
    endtask
    task automatic wait_rel(input logic v, input int n, input string name);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge i_clk);
            #1;
            if (o_tenure_release === v) break;
        end
        check(name, {31'h0, o_tenure_release}, {31'h0, v});
    endtask

    // ==========================================
    // Read-data watcher and timeout
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
        if (o_cfg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", {31'h0, o_cfg_rvalid}, 32'h0000_0000);
            else check("read data", o_cfg_rdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        seed = 32'h0000_58dd;
        ivl = `PCICFG_REQ_IVL_RST;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        cfg_rd(`PCICFG_OFS_INT_DW, {ivl, 8'h00, `PCICFG_INT_SEL_VAL, 8'h00}, 32'hFFFF_FFFF);
        cfg_rd(`PCICFG_OFS_IOBASE_DW, 32'h0000_0000, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 32'h0000_000F : (i == 1) ? 32'h0000_00FF : $random(seed);
            rl = d[7:0];
            cfg_wr(`PCICFG_OFS_INT_DW, 4'hF, d);
            @(posedge i_clk);
            #1 check("routing level", {24'h0, o_interrupt_routing_level}, {24'h0, rl});
            cfg_rd(`PCICFG_OFS_INT_DW, {ivl, 8'h00, `PCICFG_INT_SEL_VAL, rl}, 32'hFFFF_FFFF);
        end
        // Window base: reserved bits go out as zero
        d = $random(seed);
        d[7:0] = 8'h01;
        cfg_wr(`PCICFG_OFS_IOBASE_DW, 4'hF, d);
        cfg_rd(`PCICFG_OFS_IOBASE_DW, d, 32'hFFFF_FFFF);
        cfg_wr(`PCICFG_OFS_IOBASE_DW, 4'b0010, 32'h0000_FF00);
        d[15:8] = 8'hFF;
        cfg_rd(`PCICFG_OFS_IOBASE_DW, d, 32'hFFFF_FFFF);
        io_try({d[31:8], 8'h5A}, 1'b1);
        io_try({d[31:8] + 24'h00_0001, 8'h00}, 1'b0);
        cfg_wr(`PCICFG_OFS_IOBASE_DW, 4'hF, {d[31:8], 8'h00});
        io_try({d[31:8], 8'hFF}, 1'b0);
        // Unmapped dword reads zero and ignores writes
        cfg_wr(8'h20, 4'hF, $random(seed));
        cfg_rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
        // Tenure limit and the counter behind it
        cfg_wr(`PCICFG_OFS_LAT_DW, 4'b0010, {16'h0, lim, 3'h0, 8'h00});
        cfg_rd(`PCICFG_OFS_LAT_DW, {16'h0, lim, 3'h0, 8'h00}, 32'h0000_FF00);
        @(posedge i_clk);
        i_master_busy <= 1'b1;
        i_frame_start <= 1'b1;
        @(posedge i_clk);
        i_frame_start <= 1'b0;
        repeat (8 * lim + 6) @(posedge i_clk);
        #1 check("release while granted", {31'h0, o_tenure_release}, 32'h0000_0000);
        @(posedge i_clk);
        arb_slow <= 1'b1;
        arb_grant <= 1'b0;
        wait_rel(1'b1, 10, "release after grant loss");
        @(posedge i_clk);
        arb_slow <= 1'b0;
        arb_grant <= 1'b1;
        wait_rel(1'b0, 6, "release after regrant");
        @(posedge i_clk);
        i_frame_start <= 1'b1;
        arb_grant <= 1'b0;
        @(posedge i_clk);
        i_frame_start <= 1'b0;
        repeat (8 * lim - 2) @(posedge i_clk);
        #1 check("release before expiry", {31'h0, o_tenure_release}, 32'h0000_0000);
        wait_rel(1'b1, 10, "release after reload");
        @(posedge i_clk);
        i_master_busy <= 1'b0;
        arb_grant <= 1'b1;
        wait_rel(1'b0, 4, "release when idle");
        // Zero limit expires one edge after the frame starts
        lim = 5'h00;
        cfg_wr(`PCICFG_OFS_LAT_DW, 4'b0010, {16'h0, lim, 3'h0, 8'h00});
        @(posedge i_clk);
        i_master_busy <= 1'b1;
        i_frame_start <= 1'b1;
        arb_grant <= 1'b0;
        @(posedge i_clk);
        i_frame_start <= 1'b0;
        wait_rel(1'b1, 6, "release at zero limit");
        @(posedge i_clk);
        i_master_busy <= 1'b0;
        arb_grant <= 1'b1;
        // Setup byte replaces the interval; writes to it are ignored
        @(posedge i_clk);
        ivl = 8'($random(seed));
        i_ee_load <= 1'b1;
        i_ee_setup_param <= ivl;
        @(posedge i_clk);
        i_ee_load <= 1'b0;
        cfg_rd(`PCICFG_OFS_INT_DW, {ivl, 8'h00, `PCICFG_INT_SEL_VAL, rl}, 32'hFFFF_FFFF);
        cfg_wr(`PCICFG_OFS_INT_DW, 4'b1010, ~{ivl, 8'h00, `PCICFG_INT_SEL_VAL, 8'h00});
        cfg_rd(`PCICFG_OFS_INT_DW, {ivl, 8'h00, `PCICFG_INT_SEL_VAL, rl}, 32'hFFFF_FFFF);
        // Mid-run reset puts every register back to its default
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        ivl = `PCICFG_REQ_IVL_RST;
        cfg_rd(`PCICFG_OFS_INT_DW, {ivl, 8'h00, `PCICFG_INT_SEL_VAL, 8'h00}, 32'hFFFF_FFFF);
        cfg_rd(`PCICFG_OFS_LAT_DW, 32'h0000_0000, 32'hFFFF_FFFF);
        cfg_rd(`PCICFG_OFS_IOBASE_DW, 32'h0000_0000, 32'hFFFF_FFFF);
        #1 check("routing level after reset", {24'h0, o_interrupt_routing_level}, 32'h0000_0000);
        repeat (3) @(posedge i_clk);
        check("pending reads", exp_q.size(), 32'h0000_0000);
        give_verdict();
    end
endmodule
